// ==== hw/irus_defines.vh ====
// irus_defines.vh: constants of the serial register update slave
// assumes inclusion by bare name from the hw files
`ifndef IRUS_DEFINES_VH
`define IRUS_DEFINES_VH
`define IRUS_SLAVE_ADDR  7'h6b
`define IRUS_HS_CODE     5'h01
`define IRUS_NUM_REGS    5
`define IRUS_RO_INDEX    8'h03
`define IRUS_UNMAPPED    8'hff
`define IRUS_BIT_LAST    3'h7
`define IRUS_BIT_FIRST   3'h0
`define IRUS_BIT_STEP    3'h1
`define IRUS_ACK_HALF    3'h1
`define IRUS_IDX_HI      8'h04
`define IRUS_SLOT_HI     2'h3
`define IRUS_RST_REG0    8'h40
`define IRUS_RST_REG1    8'h30
`define IRUS_RST_REG2    8'h0a
`define IRUS_RST_REG4    8'h00
`endif

// ==== hw/irus_regfile.v ====
// irus_regfile.v: five 8-bit registers with registered read data
// assumes the serial engine on the same clock drives writes
`timescale 1ns/1ps
`default_nettype none
`include "irus_defines.vh"
module irus_regfile (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_we,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire [7:0] i_ro_value,
  output reg  [7:0] o_rdata
);
  reg [7:0] mem_r [0:3];

  // read-write index test, shared by write and read
  function rw_hit;
    input [7:0] a;
    begin
      rw_hit = (a < `IRUS_RO_INDEX) || (a == `IRUS_IDX_HI);
    end
  endfunction

  // index 4 folds onto the fourth slot
  function [1:0] slot;
    input [7:0] a;
    begin
      slot = (a == `IRUS_IDX_HI) ? `IRUS_SLOT_HI : a[1:0];
    end
  endfunction

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_r[0] <= `IRUS_RST_REG0;
      mem_r[1] <= `IRUS_RST_REG1;
      mem_r[2] <= `IRUS_RST_REG2;
      mem_r[3] <= `IRUS_RST_REG4;
      o_rdata  <= `IRUS_UNMAPPED;
    end else begin
      if (i_we && rw_hit(i_addr)) begin
        mem_r[slot(i_addr)] <= i_wdata;
      end
      if (i_addr == `IRUS_RO_INDEX) begin
        o_rdata <= i_ro_value;
      end else if (rw_hit(i_addr)) begin
        o_rdata <= mem_r[slot(i_addr)];
      end else begin
        o_rdata <= `IRUS_UNMAPPED;
      end
    end
  end
endmodule // irus_regfile
`default_nettype wire

// ==== hw/irus_slave.v ====
// irus_slave.v: two-wire serial slave updating four of five control registers
// assumes bus pins arrive asynchronous and open-drain, oe low drives
`timescale 1ns/1ps
`default_nettype none
`include "irus_defines.vh"
module irus_slave (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_scl,
  input  wire       i_sda,
  input  wire [7:0] i_ro_value,
  output reg        o_sda_out,
  output reg        o_sda_oe_n,
  output reg        o_hs_mode,
  output reg  [7:0] o_rd_data
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_IDX  = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_ACK  = 5'h10;

  reg  [1:0] scl_s_r;
  reg  [1:0] sda_s_r;
  reg        scl_d_r;
  reg        sda_d_r;
  reg  [4:0] st_r;
  reg  [4:0] ret_r;
  reg  [2:0] bit_r;
  reg  [7:0] sh_r;
  reg  [7:0] idx_r;
  reg        ack_r;
  reg        wr_pend_r;
  reg        we_r;
  reg  [7:0] wdata_r;
  wire       scl      = scl_s_r[1];
  wire       sda      = sda_s_r[1];
  wire       scl_rise = scl & ~scl_d_r;
  wire       scl_fall = ~scl & scl_d_r;
  // data moving while the clock stays high marks frame edges
  wire       start_c  = scl & scl_d_r & sda_d_r & ~sda;
  wire       stop_c   = scl & scl_d_r & ~sda_d_r & sda;
  wire [7:0] byte_in  = {sh_r[6:0], sda};
  wire       byte_end = scl_rise & (bit_r == `IRUS_BIT_LAST);
  wire [7:0] rdata;

  function addr_hit;
    input [7:0] b;
    begin
      addr_hit = (b[7:1] == `IRUS_SLAVE_ADDR);
    end
  endfunction

  function hs_hit;
    input [7:0] b;
    begin
      hs_hit = (b[7:3] == `IRUS_HS_CODE);
    end
  endfunction

  // two flip-flops ahead of any logic
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], i_scl};
      sda_s_r <= {sda_s_r[0], i_sda};
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  // byte engine; no glitch filter, bus clock must stay slow
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r      <= ST_IDLE;
      ret_r     <= ST_IDLE;
      bit_r     <= `IRUS_BIT_FIRST;
      sh_r      <= 8'h00;
      idx_r     <= 8'h00;
      ack_r     <= 1'b0;
      wr_pend_r <= 1'b0;
      wdata_r   <= 8'h00;
    end else if (stop_c) begin
      st_r <= ST_IDLE;
    end else if (start_c) begin
      // first byte is the address, mid-byte start restarts
      st_r  <= ST_ADDR;
      bit_r <= `IRUS_BIT_FIRST;
    end else begin
      case (st_r)
        ST_IDLE: begin
          bit_r <= `IRUS_BIT_FIRST;
        end
        ST_ADDR, ST_IDX, ST_DATA: begin
          if (scl_rise) begin
            sh_r  <= byte_in;
            bit_r <= bit_r + `IRUS_BIT_STEP;
          end
          if (byte_end) begin
            st_r      <= ST_ACK;
            ack_r     <= 1'b1;
            wr_pend_r <= 1'b0;
            if (st_r == ST_ADDR) begin
              ret_r <= ST_IDX;
              // mismatch: no ack, ignored till start
              if (!addr_hit(byte_in)) begin
                ack_r <= 1'b0;
                ret_r <= ST_IDLE;
              end
            end else if (st_r == ST_IDX) begin
              idx_r <= byte_in;
              ret_r <= ST_DATA;
            end else begin
              // next pair starts with an index
              wdata_r   <= byte_in;
              wr_pend_r <= 1'b1;
              ret_r     <= ST_IDX;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (bit_r == `IRUS_BIT_FIRST) begin
              bit_r <= `IRUS_ACK_HALF;
            end else begin
              bit_r <= `IRUS_BIT_FIRST;
              st_r  <= ret_r;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // commit strobe on the fall ending the ack
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      we_r <= 1'b0;
    end else begin
      // one-clock strobe, the store writes on the next edge
      we_r <= ~stop_c & ~start_c & (st_r == ST_ACK) & scl_fall &
              (bit_r != `IRUS_BIT_FIRST) & wr_pend_r;
    end
  end

  // data line drive, released outside acks
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sda_out  <= 1'b1;
      o_sda_oe_n <= 1'b1;
    end else if (stop_c || start_c) begin
      o_sda_oe_n <= 1'b1;
    end else if (st_r == ST_ACK && scl_fall) begin
      // low over the ninth high phase
      // driven only after the eighth fall, so bit 0 is not clipped
      o_sda_out  <= 1'b0;
      o_sda_oe_n <= ~ack_r | (bit_r != `IRUS_BIT_FIRST);
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hs_mode <= 1'b0;
    end else if (stop_c) begin
      o_hs_mode <= 1'b0;
    end else if (!start_c && byte_end && st_r == ST_ADDR &&
                 hs_hit(byte_in)) begin
      o_hs_mode <= 1'b1;
    end
  end

  // read data follows the latched index
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= `IRUS_UNMAPPED;
    end else begin
      o_rd_data <= rdata;
    end
  end

  irus_regfile u_regs (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_we       (we_r),
    .i_addr     (idx_r),
    .i_wdata    (wdata_r),
    .i_ro_value (i_ro_value),
    .o_rdata    (rdata)
  );
endmodule // irus_slave
`default_nettype wire

// ==== verif/irus_master.sv ====
// irus_master.sv: behavioural bus master, 160 ns bus clock
// assumes a pull-up on data, so released reads one
`timescale 1ns/1ps
`default_nettype none
module irus_master (
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  initial {o_scl, o_sda} = 2'b11;
  task start;
    #40 o_sda = 1'b1;
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b0;
    #40 o_scl = 1'b0;
  endtask
  task stop;
    #40 o_sda = 1'b0;
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b1;
  endtask
  task xfer(input logic [7:0] d, output logic [7:0] ack);
    for (int i = 8; i >= 0; i--) begin
      #40 o_sda = (i == 0) ? 1'b1 : d[i-1];
      #40 o_scl = 1'b1;
      #40 ack = {7'h0, !i_sda};
      #40 o_scl = 1'b0;
    end
  endtask
endmodule // irus_master
`default_nettype wire

// ==== verif/irus_slave_props.sv ====
// irus_slave_props.sv: bus-side checks of the slave
// assumes a 50 MHz clock and a 160 ns bus clock
`timescale 1ns/1ps
`default_nettype none
module irus_slave_props (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic [7:0] i_ro_value,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe_n,
  input wire logic       o_hs_mode,
  input wire logic [7:0] o_rd_data
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence stop_s; i_scl && $past(i_scl) && $rose(i_sda); endsequence
  sequence ack_s; $fell(o_sda_oe_n); endsequence
  AST_ACK_LOW: assert property (!o_sda_oe_n |-> !o_sda_out)
    else $error("ack not low");
  AST_ACK_HOLD: assert property (ack_s |=> !o_sda_oe_n [*5])
    else $error("ack short");
  AST_ACK_END: assert property (ack_s |-> ##[6:10] o_sda_oe_n)
    else $error("ack long");
  AST_ACK_ON_LOW: assert property (ack_s |-> !$past(i_scl, 2))
    else $error("ack starts at high");
  AST_ACK_OFF_LOW: assert property ($rose(o_sda_oe_n) |-> !$past(i_scl, 2))
    else $error("ack ends at high");
  AST_STOP_REL: assert property (stop_s |-> ##[1:8] o_sda_oe_n)
    else $error("bus kept");
  AST_STOP_HS: assert property (stop_s |-> ##[1:8] !o_hs_mode)
    else $error("hs kept");
  AST_HS_NOACK: assert property ($rose(o_hs_mode) |-> o_sda_oe_n [*8])
    else $error("hs code acked");
endmodule // irus_slave_props
bind irus_slave irus_slave_props i_props (.*);
`default_nettype wire

// ==== verif/irus_slave_tb.sv ====
// irus_slave_tb.sv: random updates checked against a model
// assumes the master model and the checker beside it
`timescale 1ns/1ps
`default_nettype none
module irus_slave_tb;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  ro = 8'h00;
  logic [7:0]  m [0:4] = '{8'h40, 8'h30, 8'h0a, 8'h00, 8'h00};
  logic [31:0] s = 32'hdce51be3;
  logic [7:0]  k, i1, d1, e;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  wire         scl, sdm, oe_n, so, hs;
  wire  [7:0]  rd;
  wire         sda = sdm & (oe_n | so);
  irus_master i_mst (.o_scl(scl), .o_sda(sdm), .i_sda(sda));
  irus_slave i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .i_ro_value(ro), .o_sda_out(so), .o_sda_oe_n(oe_n), .o_hs_mode(hs),
    .o_rd_data(rd));
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      wrap_up;
    end
  end
  function logic [7:0] xs;
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] x);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // wrong address: nothing acked, nothing written
  task upd(input logic [7:0] a, input int n);
    e = (a == 8'hd6) ? 8'h01 : 8'h00;
    i_mst.start;
    i_mst.xfer(a, k);
    chk(k, e);
    repeat (n) begin
      i1 = xs() & 8'h87;
      d1 = xs();
      i_mst.xfer(i1, k);
      chk(k, e);
      i_mst.xfer(d1, k);
      chk(k, e);
      if (e[0] && i1 < 8'h05 && i1 != 8'h03) m[i1[2:0]] = d1;
    end
    i_mst.stop;
  endtask
  initial begin
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    for (int j = 0; j < 24; j++) begin
      ro = xs();
      upd((j % 6 == 5) ? 8'hd4 : 8'hd6, 1 + j % 2);
      i_mst.start;
      i_mst.xfer(8'hd6, k);
      i_mst.xfer(i1, k);
      i_mst.stop;
      repeat (6) @(negedge i_clk);
      e = (i1 == 8'h03) ? ro : (i1 < 8'h05) ? m[i1[2:0]] : 8'hff;
      chk(rd, e);
      $display("test %0d done", j);
    end
    i_mst.start;
    i_mst.xfer(8'h0d, k);
    repeat (4) @(negedge i_clk);
    chk({6'h0, k[0], hs}, 8'h01);
    upd(8'hd6, 1);
    repeat (6) @(negedge i_clk);
    chk({7'h0, hs}, 8'h00);
    $display("test hs done");
    i_rst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    chk(rd, 8'h40);
    $display("test reset done");
    wrap_up;
  end
endmodule // irus_slave_tb
`default_nettype wire
